// file: rtl/qspirb_pkg.sv
// Shared constants for the quad channel serial register bank
package qspirb_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_CFG = 8'h00;
  localparam logic [7:0] ADDR_CHIP_IDENTIFIER = 8'h01;
  localparam logic [7:0] ADDR_CHAN_IDX = 8'h05;
  localparam logic [7:0] ADDR_FUNC_LO = 8'h08;
  localparam logic [7:0] ADDR_FUNC_HI = 8'h25;
  localparam logic [7:0] ADDR_FEAT_LO = 8'h3a;
  localparam logic [7:0] ADDR_FEAT_HI = 8'h3e;
  localparam logic [7:0] ADDR_COMMIT = 8'hff;
  localparam logic [7:0] COMMIT_VALUE = 8'h01;
  // ---------------------------------------------------------------
  // Reset values and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PORT_CFG = 8'h18;
  localparam logic [7:0] RST_CHAN_IDX = 8'hcf;
  localparam logic [7:0] PORT_CFG_ONES = 8'h18;
  localparam logic [7:0] PORT_CFG_LSB = 8'h42;
  localparam logic [7:0] PORT_CFG_SRST = 8'h24;
  // Arbitrary neutral identifier value
  localparam logic [7:0] CHIP_IDENTIFIER_DEFAULT = 8'h5a;
  localparam int NUM_CHAN = 4;
  localparam int SHADOW_DEPTH = 64;
  // Instruction layout: rw, len[1:0], addr[12:0]
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  // ---------------------------------------------------------------
  // Host side
  // ---------------------------------------------------------------
  localparam logic [7:0] HOST_REG_CTRL = 8'h00;
  localparam logic [7:0] HOST_REG_ADDR = 8'h04;
  localparam logic [7:0] HOST_REG_WDATA = 8'h08;
  localparam logic [7:0] HOST_REG_STATUS = 8'h0c;
  localparam int SCLK_HALF_CYCLES = 4;
endpackage : qspirb_pkg

// file: rtl/qspirb_if.sv
// Three wire serial port between host and register bank
`timescale 1ns/1ps
`default_nettype none
interface qspirb_if;
  logic serialClk;
  logic portSelectN;
  logic dataHostOut;
  logic dataHostOeN;
  logic dataDevOut;
  logic dataDevOeN;
  logic dataLine;
  // Wire level resolved from the enables, pulled high when idle
  assign dataLine = !dataHostOeN ? dataHostOut : (!dataDevOeN ? dataDevOut : 1'b1);
  modport host (output serialClk, output portSelectN, output dataHostOut,
    output dataHostOeN, input dataLine);
  modport device (input serialClk, input portSelectN, output dataDevOut,
    output dataDevOeN, input dataLine);
endinterface : qspirb_if
`default_nettype wire

// file: rtl/qspirb_device.sv
// Device end: serial slave with register map and shadow copies
//
// Functional notes
// - Clock and select are inputs only
// - Data pin driven only during readback
// - Host idles port during critical sampling
// - Host writes zero into open bits
// - Host never writes wholly open addresses
// - Reset loads documented defaults
// - Function registers write staging copy only
// - Commit write copies staging to active
// - Commit bit clears itself after copy
// - Local registers per channel, index selected
// - Multi select write reaches every channel
// - Multi select read returns first channel
// - Global registers ignore channel index
// - Port configuration mirrored, default 0x18
// - Host sets all channels before configuration
// - Configuration at 0x00, identifier at 0x01
// - Decode index, commit, function, feature ranges
// - Sixteen bit instruction, first bit read
// - Length code selects data byte count
// - Frame starts on select fall
// - MSB first until LSB first chosen
`timescale 1ns/1ps
`default_nettype none
module qspirb_device
  import qspirb_pkg::*;
#(
  parameter logic [7:0] CHIP_IDENTIFIER = CHIP_IDENTIFIER_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  qspirb_if.device port,
  input wire logic [5:0] activeAddr,
  input wire logic [1:0] activeChan,
  output logic [7:0] activeData,
  output logic softReset,
  output logic commitDone
);
  // ---------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [1:0] clkSync, selSync, datSync;
  logic clkPrev, selPrev;
  logic riseEdge, fallEdge, selFall, selHigh;
  // Two flops per pin; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync <= 2'b00;
      selSync <= 2'b11;
      datSync <= 2'b00;
      clkPrev <= 1'b0;
      selPrev <= 1'b1;
    end else begin
      clkSync <= {clkSync[0], port.serialClk};
      selSync <= {selSync[0], port.portSelectN};
      datSync <= {datSync[0], port.dataLine};
      clkPrev <= clkSync[1];
      selPrev <= selSync[1];
    end
  end
  assign selHigh = selSync[1];
  assign riseEdge = clkSync[1] && !clkPrev && !selHigh;
  assign fallEdge = !clkSync[1] && clkPrev && !selHigh;
  assign selFall = !selSync[1] && selPrev;
  // ---------------------------------------------------------------
  // Frame engine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_INSTR = 3'b001,
    S_DATA = 3'b010,
    S_DONE = 3'b100
  } qspirb_state_type;
  qspirb_state_type state;
  logic [15:0] shiftReg;
  logic [4:0] bitCount;
  logic isRead;
  logic [1:0] lenCode;
  logic [12:0] curAddr;
  logic [7:0] txByte;
  logic [2:0] bytesLeft;
  logic streaming;
  logic lsbFirst;
  logic [7:0] portCfg, chanIdx;
  logic [7:0] stage [NUM_CHAN][SHADOW_DEPTH];
  logic [7:0] active [NUM_CHAN][SHADOW_DEPTH];
  logic commitToggle;
  logic [7:0] readValue;
  logic wrStrobe;
  logic [7:0] wrByte;
  logic [15:0] next_shift;
  logic inShadow, inRange;
  // Assemble next shift value in the chosen bit order
  always_comb begin
    if (lsbFirst && state != S_INSTR)
      next_shift = {8'h00, datSync[1], shiftReg[7:1]};
    else
      next_shift = {shiftReg[14:0], datSync[1]};
  end
  assign inShadow = curAddr[7:0] >= ADDR_FUNC_LO && curAddr[7:0] <= ADDR_FEAT_HI;
  assign inRange = (curAddr[7:0] <= ADDR_FUNC_HI) || (curAddr[7:0] >= ADDR_FEAT_LO);
  // Sequence instruction and data bytes across rising edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_INSTR;
      shiftReg <= 16'h0000;
      bitCount <= 5'd0;
      isRead <= 1'b0;
      lenCode <= 2'b00;
      curAddr <= 13'h0000;
      bytesLeft <= 3'd0;
      streaming <= 1'b0;
      wrStrobe <= 1'b0;
      wrByte <= 8'h00;
    end else begin
      wrStrobe <= 1'b0;
      if (selFall && state == S_DONE) begin
        state <= S_INSTR;
        bitCount <= 5'd0;
      end else if (riseEdge) begin
        shiftReg <= next_shift;
        bitCount <= bitCount + 5'd1;
        case (state)
          S_INSTR: begin
            if (bitCount == 5'(INSTR_BITS - 1)) begin
              isRead <= shiftReg[14];
              lenCode <= shiftReg[13:12];
              curAddr <= {shiftReg[11:0], datSync[1]};
              bytesLeft <= {1'b0, shiftReg[13:12]} + 3'd1;
              streaming <= shiftReg[13:12] == 2'b11;
              bitCount <= 5'd0;
              state <= S_DATA;
            end
          end
          S_DATA: begin
            if (bitCount == 5'(BYTE_BITS - 1)) begin
              bitCount <= 5'd0;
              wrStrobe <= !isRead && inRange;
              wrByte <= lsbFirst ? next_shift[7:0] : next_shift[7:0];
              curAddr <= lsbFirst ? curAddr + 13'd1 : curAddr - 13'd1;
              if (!streaming) begin
                bytesLeft <= bytesLeft - 3'd1;
                if (bytesLeft == 3'd1)
                  state <= S_DONE;
              end
            end
          end
          default: state <= S_DONE;
        endcase
      end
      if (selFall && state != S_DONE && bitCount == 5'd0 && state == S_INSTR)
        shiftReg <= 16'h0000;
    end
  end
  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  logic [1:0] firstChan;
  always_comb begin
    firstChan = chanIdx[0] ? 2'd0 : chanIdx[1] ? 2'd1 : chanIdx[2] ? 2'd2 : 2'd3;
    readValue = 8'h00;
    case (curAddr[7:0])
      ADDR_PORT_CFG: readValue = portCfg;
      ADDR_CHIP_IDENTIFIER: readValue = CHIP_IDENTIFIER;
      ADDR_CHAN_IDX: readValue = chanIdx;
      ADDR_COMMIT: readValue = 8'h00;
      default: if (inShadow && inRange) readValue = stage[firstChan][curAddr[5:0]];
    endcase
  end
  // Drive data on falling edges during readback only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txByte <= 8'h00;
      port.dataDevOut <= 1'b0;
      port.dataDevOeN <= 1'b1;
    end else begin
      if (selHigh || state != S_DATA || !isRead) begin
        port.dataDevOeN <= 1'b1;
      end else if (fallEdge) begin
        port.dataDevOeN <= 1'b0;
        if (bitCount == 5'd0) begin
          port.dataDevOut <= lsbFirst ? readValue[0] : readValue[7];
          txByte <= lsbFirst ? {1'b0, readValue[7:1]} : {readValue[6:0], 1'b0};
        end else begin
          port.dataDevOut <= lsbFirst ? txByte[0] : txByte[7];
          txByte <= lsbFirst ? {1'b0, txByte[7:1]} : {txByte[6:0], 1'b0};
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // Global registers
  // ---------------------------------------------------------------
  assign lsbFirst = portCfg[6] | portCfg[1];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      portCfg <= RST_PORT_CFG;
      chanIdx <= RST_CHAN_IDX;
      softReset <= 1'b0;
      commitToggle <= 1'b0;
    end else begin
      softReset <= 1'b0;
      if (wrStrobe) begin
        case (curAddr[7:0] + (lsbFirst ? 8'hff : 8'h01))
          ADDR_PORT_CFG: begin
            // Either half of the mirrored pair sets the field; ones fixed
            portCfg <= PORT_CFG_ONES | ((wrByte[6] | wrByte[1]) ? PORT_CFG_LSB : 8'h00);
            softReset <= wrByte[5] | wrByte[2];
          end
          ADDR_CHAN_IDX: chanIdx <= wrByte & RST_CHAN_IDX;
          ADDR_COMMIT: if (wrByte == COMMIT_VALUE) commitToggle <= !commitToggle;
          default: ;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // Staging copies, one per channel
  // ---------------------------------------------------------------
  logic [7:0] wrAddr;
  assign wrAddr = curAddr[7:0] + (lsbFirst ? 8'hff : 8'h01);
  logic [2:0] cmtSync;
  logic commitPulse;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmtSync <= 3'b000;
      commitDone <= 1'b0;
    end else begin
      cmtSync <= {cmtSync[1:0], commitToggle};
      commitDone <= commitPulse;
    end
  end
  assign commitPulse = cmtSync[2] ^ cmtSync[1];
  generate
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          for (int a = 0; a < SHADOW_DEPTH; a++) begin
            stage[c][a] <= 8'h00;
            active[c][a] <= 8'h00;
          end
        end else begin
          if (wrStrobe && chanIdx[c] && wrAddr >= ADDR_FUNC_LO && wrAddr <= ADDR_FEAT_HI)
            stage[c][wrAddr[5:0]] <= wrByte;
          if (commitPulse)
            active[c] <= stage[c];
        end
      end
    end
  endgenerate
  // Active copy lookup for the converter logic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      activeData <= 8'h00;
    else
      activeData <= active[activeChan][activeAddr];
  end
endmodule : qspirb_device
`default_nettype wire

// file: rtl/qspirb_host.sv
// Host end: Wishbone controlled serial master
`timescale 1ns/1ps
`default_nettype none
module qspirb_host
  import qspirb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  qspirb_if.host port
);
  // ---------------------------------------------------------------
  // Command registers
  // ---------------------------------------------------------------
  logic [12:0] cmdAddr;
  logic [7:0] cmdData, rxData;
  logic cmdRead, busy, startReq;
  logic [1:0] datSync;
  // Wishbone slave, one wait state answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cmdAddr <= 13'h0000;
      cmdData <= 8'h00;
      cmdRead <= 1'b0;
      startReq <= 1'b0;
    end else begin
      startReq <= 1'b0;
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= 32'h0000_0000;
        if (wb_we_i && wb_sel_i[0]) begin
          case (wb_adr_i)
            HOST_REG_CTRL: if (!busy) begin
              startReq <= wb_dat_i[0];
              cmdRead <= wb_dat_i[1];
            end
            HOST_REG_ADDR: cmdAddr <= wb_dat_i[12:0];
            HOST_REG_WDATA: cmdData <= wb_dat_i[7:0] ;
            default: ;
          endcase
        end else if (!wb_we_i) begin
          case (wb_adr_i)
            HOST_REG_ADDR: wb_dat_o <= {19'h0, cmdAddr};
            HOST_REG_WDATA: wb_dat_o <= {24'h0, cmdData};
            HOST_REG_STATUS: wb_dat_o <= {23'h0, rxData, busy};
            default: wb_dat_o <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // Serial engine: one byte per frame, MSB first
  // ---------------------------------------------------------------
  logic [23:0] txShift;
  logic [4:0] bitIdx;
  logic [2:0] divCount;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) datSync <= 2'b00;
    else datSync <= {datSync[0], port.dataLine};
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      txShift <= 24'h000000;
      bitIdx <= 5'd0;
      divCount <= 3'd0;
      rxData <= 8'h00;
      port.serialClk <= 1'b0;
      port.portSelectN <= 1'b1;
      port.dataHostOut <= 1'b0;
      port.dataHostOeN <= 1'b1;
    end else if (startReq && !busy) begin
      busy <= 1'b1;
      txShift <= {cmdRead, 2'b00, cmdAddr, cmdData};
      bitIdx <= 5'd0;
      divCount <= 3'd0;
      port.portSelectN <= 1'b0;
      port.dataHostOut <= cmdRead;
      port.dataHostOeN <= 1'b0;
    end else if (busy) begin
      divCount <= divCount + 3'd1;
      if (divCount == 3'(SCLK_HALF_CYCLES - 1)) begin
        divCount <= 3'd0;
        port.serialClk <= !port.serialClk;
        if (port.serialClk) begin
          // Sample readback at the end of the high phase; the far end's
          // sync delay plus ours outlasts half a period
          if (cmdRead && bitIdx >= 5'd16)
            rxData <= {rxData[6:0], datSync[1]};
          bitIdx <= bitIdx + 5'd1;
          if (bitIdx == 5'd23) begin
            busy <= 1'b0;
            port.portSelectN <= 1'b1;
            port.dataHostOeN <= 1'b1;
          end else begin
            txShift <= {txShift[22:0], 1'b0};
            port.dataHostOut <= txShift[22];
            port.dataHostOeN <= cmdRead && bitIdx >= 5'd15;
          end
        end
      end
    end
  end
endmodule : qspirb_host
`default_nettype wire

// file: tb/qspirb_chk.sv
// Checker for the serial link between host end and device end
`timescale 1ns/1ps
`default_nettype none
module qspirb_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serialClk,
  input wire logic portSelectN,
  input wire logic dataHostOut,
  input wire logic dataHostOeN,
  input wire logic dataDevOut,
  input wire logic dataDevOeN,
  input wire logic dataLine
);
  logic prevClk;
  logic [7:0] edgeCnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Counts rising serial clock edges inside one frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevClk <= 1'b0;
      edgeCnt <= 8'h00;
    end else begin
      prevClk <= serialClk;
      if (portSelectN) edgeCnt <= 8'h00;
      else if (serialClk && !prevClk) edgeCnt <= edgeCnt + 8'h01;
    end
  end
  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  dev_idle_a: assert property (portSelectN |-> dataDevOeN)
    else $error("device drives data while deselected");
  no_fight_a: assert property (dataHostOeN || dataDevOeN)
    else $error("both ends drive the data line");
  read_phase_a: assert property (!dataDevOeN |-> edgeCnt >= 8'h10)
    else $error("device drives before instruction ends");
  dev_line_a: assert property (!dataDevOeN |-> dataLine == dataDevOut)
    else $error("data line does not follow device");
  clk_idle_a: assert property (portSelectN && $past(portSelectN) |-> !serialClk)
    else $error("serial clock moves outside a frame");
  sel_start_a: assert property ($fell(portSelectN) |-> !serialClk)
    else $error("frame starts with clock high");
  clk_half_a: assert property ($rose(serialClk) |-> serialClk [*4] ##1 !serialClk)
    else $error("serial clock high phase wrong");
  frame_len_a: assert property ($rose(portSelectN) |-> edgeCnt == 8'h18)
    else $error("frame is not instruction plus one byte");
  host_hold_a: assert property ($rose(serialClk) && !dataHostOeN |-> $stable(dataHostOut))
    else $error("host data changes at sampling edge");
  cover property ($rose(portSelectN) && edgeCnt == 8'h18);
  cover property ($fell(dataDevOeN));
  cover property ($fell(portSelectN));
endmodule : qspirb_chk
`default_nettype wire

// file: tb/tb_quad_channel_spi_register_bank.sv
// Self-checking bench for host and device ends joined by the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s expected %h seen %h", n, e, a); end end
module tb_quad_channel_spi_register_bank;
  import qspirb_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0, wbDatR;
  logic [5:0] actAddr = 6'h00;
  logic [1:0] actChan = 2'h0;
  logic [7:0] actData, chIdx, rd, v, a;
  logic softReset, commitDone;
  logic lsbMode = 1'b0;
  logic [7:0] stg [4][64];
  logic [7:0] act [4][64];
  logic [7:0] addrQ [$];
  int n_mismatch = 0, checked = 0, nCommit = 0, nSoft = 0, seed = 32053, n0;
  qspirb_if link ();
  qspirb_host u_qspirb_host (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h1),
    .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .port(link.host));
  qspirb_device u_qspirb_device (.sys_clk(sys_clk), .rst_n(rst_n), .port(link.device),
    .activeAddr(actAddr), .activeChan(actChan), .activeData(actData),
    .softReset(softReset), .commitDone(commitDone));
  qspirb_chk u_qspirb_chk (.sys_clk(sys_clk), .rst_n(rst_n), .serialClk(link.serialClk),
    .portSelectN(link.portSelectN), .dataHostOut(link.dataHostOut),
    .dataHostOeN(link.dataHostOeN), .dataDevOut(link.dataDevOut),
    .dataDevOeN(link.dataDevOeN), .dataLine(link.dataLine));
  // Clock and pulse counters
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    nCommit += (commitDone === 1'b1);
    nSoft += (softReset === 1'b1);
  end
  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic finish_test();
    $display("Counts: checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= ad;
    wbDatW <= d;
    do @(posedge sys_clk); while (wbAck !== 1'b1 && ++n < 100);
    if (n >= 100) n_mismatch++;
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  // One serial frame through the host registers
  task automatic xfer(input logic r, input logic [7:0] ad, input logic [7:0] d,
                      output logic [7:0] q);
    logic [31:0] s;
    int n;
    n = 0;
    wb(1'b1, HOST_REG_ADDR, {24'h0, ad}, s);
    wb(1'b1, HOST_REG_WDATA, {24'h0, d}, s);
    wb(1'b1, HOST_REG_CTRL, {30'h0, r, 1'b1}, s);
    do wb(1'b0, HOST_REG_STATUS, 32'h0, s); while (s[0] !== 1'b0 && ++n < 200);
    if (n >= 200) n_mismatch++;
    q = s[8:1];
  endtask
  // Bit reversal: the host always shifts MSB first
  function automatic logic [7:0] rev(input logic [7:0] x);
    for (int i = 0; i < 8; i++) rev[i] = x[7 - i];
  endfunction
  // Write with the reference model kept in step; in LSB mode the byte lands reversed
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    logic [7:0] q, dd;
    dd = lsbMode ? rev(d) : d;
    xfer(1'b0, ad, d, q);
    if (ad == 8'h00) lsbMode = dd[6] | dd[1];
    if (ad == 8'h05) chIdx = dd;
    if (ad >= 8'h08 && ad <= 8'h3e)
      for (int c = 0; c < 4; c++) if (chIdx[c]) stg[c][ad[5:0]] = dd;
    if (ad == 8'hff && dd == 8'h01) act = stg;
  endtask
  task automatic peek(input int c, input logic [7:0] ad, output logic [7:0] q);
    @(posedge sys_clk);
    actChan <= 2'(c);
    actAddr <= ad[5:0];
    repeat (2) @(posedge sys_clk);
    q = actData;
  endtask
  task automatic commit();
    n0 = nCommit;
    wr(8'hff, 8'h01);
    for (int i = 0; i < 60 && nCommit == n0; i++) @(posedge sys_clk);
  endtask
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    #400000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    chIdx = 8'hcf;
    for (int c = 0; c < 4; c++) for (int i = 0; i < 64; i++) stg[c][i] = 8'h00;
    act = stg;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    xfer(1'b1, 8'h00, 8'h00, rd);
    `CHK("port cfg", 8'h18, rd)
    xfer(1'b1, 8'h01, 8'h00, rd);
    `CHK("chip_identifier", CHIP_IDENTIFIER_DEFAULT, rd)
    xfer(1'b1, 8'h05, 8'h00, rd);
    `CHK("chan index", 8'hcf, rd)
    $display("Test reset values done");
    wr(8'h05, 8'h03);
    wr(8'h10, 8'ha5);
    peek(0, 8'h10, rd);
    `CHK("staged only", 8'h00, rd)
    xfer(1'b1, 8'h10, 8'h00, rd);
    `CHK("multi read", stg[0][16], rd)
    commit();
    `CHK("commit pulse", n0 + 1, nCommit)
    for (int c = 0; c < 4; c++) begin
      peek(c, 8'h10, rd);
      `CHK("active copy", act[c][16], rd)
    end
    xfer(1'b1, 8'hff, 8'h00, rd);
    `CHK("commit clear", 8'h00, rd)
    $display("Test commit done");
    repeat (8) begin
      v = 8'($random(seed));
      wr(8'h05, {4'h0, (v[3:0] == 4'h0) ? 4'h1 : v[3:0]});
      a = 8'h08 + {4'h0, 4'($random(seed))};
      if (a == 8'h13) a = 8'h3c;
      addrQ.push_back(a);
      wr(a, 8'($random(seed)));
    end
    foreach (addrQ[k]) for (int c = 0; c < 4; c++) begin
      wr(8'h05, 8'(1 << c));
      xfer(1'b1, addrQ[k], 8'h00, rd);
      `CHK("local read", stg[c][addrQ[k][5:0]], rd)
      peek(c, addrQ[k], rd);
      `CHK("not yet active", act[c][addrQ[k][5:0]], rd)
    end
    commit();
    foreach (addrQ[k]) for (int c = 0; c < 4; c++) begin
      peek(c, addrQ[k], rd);
      `CHK("random active", act[c][addrQ[k][5:0]], rd)
    end
    $display("Test random channels done");
    wr(8'h05, 8'h02);
    xfer(1'b1, 8'h01, 8'h00, rd);
    `CHK("global id", CHIP_IDENTIFIER_DEFAULT, rd)
    wr(8'h05, 8'h0f);
    n0 = nSoft;
    wr(8'h00, 8'h3c);
    `CHK("soft reset", n0 + 1, nSoft)
    $display("Test global and soft reset done");
    // LSB first: data bytes reverse on the wire, instruction stays MSB first
    wr(8'h00, PORT_CFG_LSB);
    xfer(1'b1, 8'h00, 8'h00, rd);
    `CHK("lsb cfg", rev(PORT_CFG_ONES | PORT_CFG_LSB), rd)
    wr(8'h20, 8'h1d);
    xfer(1'b1, 8'h20, 8'h00, rd);
    `CHK("lsb local", rev(stg[0][32]), rd)
    wr(8'h00, PORT_CFG_ONES);
    xfer(1'b1, 8'h20, 8'h00, rd);
    `CHK("msb local", stg[0][32], rd)
    $display("Test bit order done");
    finish_test();
  end
endmodule : tb_quad_channel_spi_register_bank
`default_nettype wire
